// File: rtl/dbcs_core.sv
// Per-bank command acceptance state tracker of a DDR2 SDRAM
// ************************************************************
// Functional notes
// - Write recovery returns to active after tWR
// - Write recovery with precharge enters precharge
// - Refresh returns idle after tRC
// - Mode set returns idle after tMRD
// - Burst interrupt only with length eight
// - Second extended register bit selects hot refresh
// - Precharge returns idle after tRP
// ************************************************************
`timescale 1ns/1ps
`default_nettype none

module dbcs_core
    import dbcs_pkg::*;
#(
    parameter int NUM_BANKS = 8
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // Command bus
    input  wire dbcs_pkg::dbcs_bus_t         cmd_bus,
    // Status
    output logic [NUM_BANKS-1:0]             bank_idle,
    output logic [NUM_BANKS-1:0]             bank_busy,
    output logic                             illegal_cmd,
    output logic                             burst_len_eight,
    output logic                             high_temp_self_refresh_select_bit
);
    import dbcs_pkg::*;

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic dbcs_cmd_t decode(input dbcs_bus_t b);
        if (b.cs_n)
            return DBCS_CMD_NOP;
        case ({b.ras_n, b.cas_n, b.we_n})
            3'h7:    return DBCS_CMD_NOP;
            3'h5:    return DBCS_CMD_RD;
            3'h4:    return DBCS_CMD_WR;
            3'h3:    return DBCS_CMD_ACT;
            3'h2:    return DBCS_CMD_PRE;
            3'h1:    return DBCS_CMD_REF;
            3'h0:    return DBCS_CMD_MRS;
            default: return DBCS_CMD_NOP;
        endcase
    endfunction

    dbcs_cmd_t                cmd;
    logic [NUM_BANKS-1:0]     bad;
    logic [NUM_BANKS-1:0]     all_idle_v;
    dbcs_state_t              st_r    [NUM_BANKS];
    logic [TIMER_W-1:0]       tmr_r   [NUM_BANKS];

    assign cmd = decode(cmd_bus);

    // ************************************************************
    // Bank state machines
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            logic hit;
            logic done;
            assign hit = (cmd_bus.bank == 3'(g));
            assign done = (tmr_r[g] <= TIMER_W'(1));
            assign all_idle_v[g] = (st_r[g] == DBCS_ST_IDLE);

            always_comb begin
                bad[g] = 1'b0;
                case (st_r[g])
                    DBCS_ST_IDLE:    bad[g] = hit && (cmd == DBCS_CMD_RD || cmd == DBCS_CMD_WR);
                    DBCS_ST_ACTIVE:  bad[g] = hit && (cmd == DBCS_CMD_ACT);
                    DBCS_ST_WREC: begin
                        bad[g] = hit && (cmd != DBCS_CMD_NOP) && (cmd != DBCS_CMD_WR);
                        // Burst is folded in here, so a new write cuts it short
                        if (hit && (cmd == DBCS_CMD_WR) && !burst_len_eight)
                            bad[g] = 1'b1;
                    end
                    DBCS_ST_WRECAP:  bad[g] = hit && (cmd != DBCS_CMD_NOP);
                    DBCS_ST_PRECH:   bad[g] = hit && (cmd != DBCS_CMD_NOP) && (cmd != DBCS_CMD_PRE);
                    DBCS_ST_REFR:    bad[g] = (cmd != DBCS_CMD_NOP);
                    DBCS_ST_MRACC:   bad[g] = (cmd != DBCS_CMD_NOP);
                    default:         bad[g] = 1'b0;
                endcase
                // Refresh and mode set need every bank idle
                if ((cmd == DBCS_CMD_REF || cmd == DBCS_CMD_MRS) && st_r[g] != DBCS_ST_IDLE)
                    bad[g] = 1'b1;
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    st_r[g]  <= DBCS_ST_IDLE;
                    tmr_r[g] <= '0;
                end else if (!(|bad)) begin
                    if (tmr_r[g] != '0)
                        tmr_r[g] <= tmr_r[g] - TIMER_W'(1);
                    case (st_r[g])
                        DBCS_ST_IDLE: begin
                            if (cmd == DBCS_CMD_ACT && hit)
                                st_r[g] <= DBCS_ST_ACTIVE;
                            else if (cmd == DBCS_CMD_PRE && (hit || cmd_bus.addr[10])) begin
                                st_r[g]  <= DBCS_ST_PRECH;
                                tmr_r[g] <= TIMER_W'(TRP_CYC);
                            end else if (cmd == DBCS_CMD_REF) begin
                                st_r[g]  <= DBCS_ST_REFR;
                                tmr_r[g] <= TIMER_W'(TRC_CYC);
                            end else if (cmd == DBCS_CMD_MRS) begin
                                st_r[g]  <= DBCS_ST_MRACC;
                                tmr_r[g] <= TIMER_W'(TMRD_CYC);
                            end
                        end
                        DBCS_ST_ACTIVE: begin
                            // Burst phase is folded into the recovery timer
                            if (cmd == DBCS_CMD_WR && hit) begin
                                st_r[g]  <= cmd_bus.addr[10] ? DBCS_ST_WRECAP : DBCS_ST_WREC;
                                tmr_r[g] <= TIMER_W'(TWR_CYC);
                            end else if (cmd == DBCS_CMD_PRE && (hit || cmd_bus.addr[10])) begin
                                st_r[g]  <= DBCS_ST_PRECH;
                                tmr_r[g] <= TIMER_W'(TRP_CYC);
                            end
                        end
                        DBCS_ST_WREC: begin
                            if (cmd == DBCS_CMD_WR && hit) begin
                                st_r[g]  <= cmd_bus.addr[10] ? DBCS_ST_WRECAP : DBCS_ST_WREC;
                                tmr_r[g] <= TIMER_W'(TWR_CYC);
                            end else if (done)
                                st_r[g] <= DBCS_ST_ACTIVE;
                        end
                        DBCS_ST_WRECAP: begin
                            if (done) begin
                                st_r[g]  <= DBCS_ST_PRECH;
                                tmr_r[g] <= TIMER_W'(TRP_CYC);
                            end
                        end
                        DBCS_ST_PRECH: begin
                            if (cmd == DBCS_CMD_PRE && hit)
                                st_r[g] <= st_r[g];
                            else if (done)
                                st_r[g] <= DBCS_ST_IDLE;
                        end
                        DBCS_ST_REFR: begin
                            if (done)
                                st_r[g] <= DBCS_ST_IDLE;
                        end
                        DBCS_ST_MRACC: begin
                            if (done)
                                st_r[g] <= DBCS_ST_IDLE;
                        end
                        default: st_r[g] <= DBCS_ST_IDLE;
                    endcase
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    bank_idle[g] <= 1'b1;
                    bank_busy[g] <= 1'b0;
                end else begin
                    bank_idle[g] <= (st_r[g] == DBCS_ST_IDLE);
                    bank_busy[g] <= (st_r[g] != DBCS_ST_IDLE) && (st_r[g] != DBCS_ST_ACTIVE);
                end
            end
        end
    endgenerate

    // ************************************************************
    // Mode register shadow
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burst_len_eight                   <= 1'b0;
            high_temp_self_refresh_select_bit <= 1'b0;
        end else if (cmd == DBCS_CMD_MRS && (&all_idle_v)) begin
            if (cmd_bus.mr_sel == 2'h0)
                burst_len_eight <= (cmd_bus.addr[BL_LSB +: 3] == BL_EIGHT);
            if (cmd_bus.mr_sel == MR_SEL_EXT2)
                high_temp_self_refresh_select_bit <= cmd_bus.addr[HT_SELF_REF_BIT];
        end
    end

    // Hot refresh rate and boundary placement are left to the controller
    always_ff @(posedge clock) begin
        if (!rst_n)
            illegal_cmd <= 1'b0;
        else
            illegal_cmd <= |bad;
    end

endmodule

`default_nettype wire

// File: rtl/dbcs_pkg.sv
// Package for the DDR2 bank command state tracker
package dbcs_pkg;

    // ************************************************************
    // Timing, 40 MHz command clock
    // ************************************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int TWR_NS        = 15;
    localparam int TRP_NS        = 15;
    localparam int TRC_NS        = 60;
    localparam int TMRD_CK       = 2;
    localparam int TWR_CYC  = ((TWR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                              ((TWR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int TRP_CYC  = ((TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                              ((TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int TRC_CYC  = ((TRC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                              ((TRC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int TMRD_CYC = TMRD_CK;
    localparam int TIMER_W  = 4;

    // ************************************************************
    // Mode register fields
    // ************************************************************
    localparam int          BL_LSB          = 0;
    localparam logic [2:0]  BL_EIGHT        = 3'h3;
    localparam logic [1:0]  MR_SEL_EXT2     = 2'h2;
    localparam int          HT_SELF_REF_BIT = 7;
    localparam int          ADDR_W          = 14;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        DBCS_CMD_NOP  = 4'h0,
        DBCS_CMD_RD   = 4'h1,
        DBCS_CMD_WR   = 4'h2,
        DBCS_CMD_ACT  = 4'h3,
        DBCS_CMD_PRE  = 4'h4,
        DBCS_CMD_REF  = 4'h5,
        DBCS_CMD_MRS  = 4'h6
    } dbcs_cmd_t;

    typedef enum logic [6:0] {
        DBCS_ST_IDLE   = 7'h01,
        DBCS_ST_ACTIVE = 7'h02,
        DBCS_ST_WREC   = 7'h04,
        DBCS_ST_WRECAP = 7'h08,
        DBCS_ST_PRECH  = 7'h10,
        DBCS_ST_REFR   = 7'h20,
        DBCS_ST_MRACC  = 7'h40
    } dbcs_state_t;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [2:0]        bank;
        logic [1:0]        mr_sel;
        logic [ADDR_W-1:0] addr;
    } dbcs_bus_t;

endpackage

// File: verification/dbcs_core_properties.sv
// Port-level assertions for the bank command state tracker
`timescale 1ns/1ps
`default_nettype none

module dbcs_core_properties
#(
    parameter int NUM_BANKS = 8
) (
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rst_n,
    // Watched ports
    input wire dbcs_pkg::dbcs_bus_t  cmd_bus,
    input wire logic [NUM_BANKS-1:0] bank_idle,
    input wire logic [NUM_BANKS-1:0] bank_busy,
    input wire logic                 illegal_cmd,
    input wire logic                 burst_len_eight,
    input wire logic                 high_temp_self_refresh_select_bit
);
    import dbcs_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic nonnop;
    logic ref_c;
    logic mrs_c;
    logic wr_c;
    assign nonnop = !cmd_bus.cs_n && !(cmd_bus.ras_n && cmd_bus.cas_n && cmd_bus.we_n);
    assign ref_c  = nonnop && {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} == 3'h1;
    assign mrs_c  = nonnop && {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} == 3'h0;
    assign wr_c   = nonnop && {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} == 3'h4;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_DESELECT_LEGAL: assert property (!nonnop |=> !illegal_cmd)
        else $error("deselect or nop flagged illegal");
    AST_ILLEGAL_CAUSE: assert property (illegal_cmd |-> $past(nonnop))
        else $error("illegal flag without a command");
    AST_REF_BLOCKS: assert property (ref_c ##1 (!illegal_cmd && nonnop) |=> illegal_cmd)
        else $error("command accepted during refresh");
    AST_REF_TIME: assert property (ref_c ##1 !illegal_cmd |-> ##1 (bank_idle == '0)[*3] ##[1:6] (bank_idle == '1))
        else $error("refresh period wrong");
    AST_MRS_BLOCKS: assert property (mrs_c ##1 (!illegal_cmd && nonnop) |=> illegal_cmd)
        else $error("command accepted during mode set");
    AST_MRS_TIME: assert property (mrs_c ##1 !illegal_cmd |-> ##1 (bank_idle == '0)[*2] ##[1:5] (bank_idle == '1))
        else $error("mode set delay wrong");
    AST_BL_SET: assert property (mrs_c && cmd_bus.mr_sel == 2'h0 ##1 !illegal_cmd
        |=> burst_len_eight == ($past(cmd_bus.addr[2:0], 2) == BL_EIGHT))
        else $error("burst length flag wrong");
    AST_HT_SET: assert property (mrs_c && cmd_bus.mr_sel == MR_SEL_EXT2 ##1 !illegal_cmd
        |=> high_temp_self_refresh_select_bit == $past(cmd_bus.addr[HT_SELF_REF_BIT], 2))
        else $error("hot self refresh flag wrong");
    // An accepted write leaves its bank recovering, so a second write there cuts the burst
    AST_BL4_NO_INTERRUPT: assert property ((wr_c && !burst_len_eight)
        ##1 (!illegal_cmd && wr_c && cmd_bus.bank == $past(cmd_bus.bank)) |=> illegal_cmd)
        else $error("burst of four interrupted");

    COV_REF: cover property (ref_c ##1 !illegal_cmd);
    COV_MRS: cover property (mrs_c ##1 !illegal_cmd);
    COV_ILLEGAL: cover property (illegal_cmd);
    COV_BL4_INTR: cover property ((wr_c && !burst_len_eight) ##1 (wr_c && !illegal_cmd));
endmodule

bind dbcs_core dbcs_core_properties #(.NUM_BANKS(NUM_BANKS)) dbcs_core_properties_i (
    .clock(clock), .rst_n(rst_n), .cmd_bus(cmd_bus), .bank_idle(bank_idle), .bank_busy(bank_busy),
    .illegal_cmd(illegal_cmd), .burst_len_eight(burst_len_eight),
    .high_temp_self_refresh_select_bit(high_temp_self_refresh_select_bit)
);

`default_nettype wire

// File: verification/dbcs_ctrl_model.sv
// Memory controller model driving the command bus
`timescale 1ns/1ps
`default_nettype none

module dbcs_ctrl_model (
    // Clock
    input  wire logic                clock,
    // Command bus
    output var  dbcs_pkg::dbcs_bus_t cmd_bus
);
    import dbcs_pkg::*;

    initial cmd_bus = '1;

    // One command, held on the bus until the next call; caller keeps refresh and mode set to all-idle times,
    // Burst cuts to 4-bit boundaries and the doubled refresh rate when hot
    task send(input dbcs_cmd_t c, input logic [2:0] b,
              input logic [1:0] ms, input logic [ADDR_W-1:0] a);
        logic [2:0] s;
        case (c)
            DBCS_CMD_RD:  s = 3'h5;
            DBCS_CMD_WR:  s = 3'h4;
            DBCS_CMD_ACT: s = 3'h3;
            DBCS_CMD_PRE: s = 3'h2;
            DBCS_CMD_REF: s = 3'h1;
            DBCS_CMD_MRS: s = 3'h0;
            default:      s = 3'h7;
        endcase
        @(negedge clock);
        cmd_bus <= {1'b0, s, b, ms, a};
    endtask

    // Deselect; other lines toggle so no stale value lingers
    task idle(input int n);
        dbcs_bus_t t;
        repeat (n) begin
            @(negedge clock);
            t = ~cmd_bus;
            t.cs_n = 1'b1;
            cmd_bus <= t;
        end
    endtask
endmodule

`default_nettype wire

// File: verification/ddr2_bank_command_state_rules_tb.sv
// Self-checking testbench for the bank command state tracker
`timescale 1ns/1ps
`default_nettype none

module ddr2_bank_command_state_rules_tb;
    import dbcs_pkg::*;

    logic       clock;
    logic       rst_n;
    dbcs_bus_t  cmd_bus;
    logic [7:0] bank_idle;
    logic [7:0] bank_busy;
    logic       illegal_cmd;
    logic       burst_len_eight;
    logic       ht_bit;
    int         fail_count;
    int         check_count;

    dbcs_core #(.NUM_BANKS(8)) dbcs_core_i (.clock(clock), .rst_n(rst_n), .cmd_bus(cmd_bus),
        .bank_idle(bank_idle), .bank_busy(bank_busy), .illegal_cmd(illegal_cmd),
        .burst_len_eight(burst_len_eight), .high_temp_self_refresh_select_bit(ht_bit));
    dbcs_ctrl_model dbcs_ctrl_model_i (.clock(clock), .cmd_bus(cmd_bus));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task cmd(input dbcs_cmd_t c, input logic [2:0] b, input logic [1:0] ms, input logic [13:0] a, input logic e);
        dbcs_ctrl_model_i.send(c, b, ms, a);
        dbcs_ctrl_model_i.idle(1);
        chk({7'h00, illegal_cmd}, {7'h00, e});
    endtask

    // Bounded wait; exact figures are left to the assertions
    task wait_idle(input logic [7:0] m);
        int n;
        n = 0;
        while ((bank_idle & m) !== m && n < 12) begin
            @(negedge clock);
            n++;
        end
        chk(bank_idle & m, m);
    endtask

    task t_refresh;
        dbcs_ctrl_model_i.send(DBCS_CMD_REF, 3'h0, 2'h0, 14'h0000);
        cmd(DBCS_CMD_ACT, 3'h0, 2'h0, 14'h0000, 1'b1);
        chk(bank_idle, 8'h00);
        chk(bank_busy, 8'hFF);
        wait_idle(8'hFF);
    endtask

    // Reset leaves burst length four: a write into a recovering bank is refused
    task t_burst4;
        chk({7'h00, burst_len_eight}, 8'h00);
        cmd(DBCS_CMD_ACT, 3'h3, 2'h0, 14'h0000, 1'b0);
        dbcs_ctrl_model_i.send(DBCS_CMD_WR, 3'h3, 2'h0, 14'h0000);
        cmd(DBCS_CMD_WR, 3'h3, 2'h0, 14'h0000, 1'b1);
        cmd(DBCS_CMD_PRE, 3'h3, 2'h0, 14'h0000, 1'b0);
        wait_idle(8'hFF);
    endtask

    task t_mrs;
        logic [15:0] tbl [4];
        logic        bl;
        logic        ht;
        tbl = '{16'h0002, 16'h0003, 16'h8080, 16'h8000};
        bl = 1'b0;
        ht = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (tbl[i][15:14] == 2'h0) begin
                bl = (tbl[i][2:0] == BL_EIGHT);
            end else begin
                ht = tbl[i][HT_SELF_REF_BIT];
            end
            dbcs_ctrl_model_i.send(DBCS_CMD_MRS, 3'h0, tbl[i][15:14], tbl[i][13:0]);
            cmd(DBCS_CMD_RD, 3'h0, 2'h0, 14'h0000, 1'b1);
            wait_idle(8'hFF);
            chk({7'h00, burst_len_eight}, {7'h00, bl});
            chk({7'h00, ht_bit}, {7'h00, ht});
        end
    endtask

    task t_wrec;
        cmd(DBCS_CMD_ACT, 3'h1, 2'h0, 14'h0000, 1'b0);
        dbcs_ctrl_model_i.send(DBCS_CMD_WR, 3'h1, 2'h0, 14'h0000);
        cmd(DBCS_CMD_RD, 3'h1, 2'h0, 14'h0000, 1'b1);
        dbcs_ctrl_model_i.send(DBCS_CMD_WR, 3'h1, 2'h0, 14'h0000);
        cmd(DBCS_CMD_WR, 3'h1, 2'h0, 14'h0000, 1'b0);
        dbcs_ctrl_model_i.send(DBCS_CMD_WR, 3'h1, 2'h0, 14'h0000);
        cmd(DBCS_CMD_ACT, 3'h2, 2'h0, 14'h0000, 1'b0);
        dbcs_ctrl_model_i.idle(4);
        chk(bank_busy & 8'h06, 8'h00);
        chk(bank_idle & 8'h06, 8'h00);
        cmd(DBCS_CMD_REF, 3'h0, 2'h0, 14'h0000, 1'b1);
        dbcs_ctrl_model_i.send(DBCS_CMD_WR, 3'h1, 2'h0, 14'h0400);
        cmd(DBCS_CMD_WR, 3'h1, 2'h0, 14'h0400, 1'b1);
        chk(bank_busy & 8'h02, 8'h02);
        wait_idle(8'h02);
        dbcs_ctrl_model_i.send(DBCS_CMD_PRE, 3'h2, 2'h0, 14'h0000);
        cmd(DBCS_CMD_PRE, 3'h2, 2'h0, 14'h0000, 1'b0);
        wait_idle(8'hFF);
    endtask

    task wrap_up;
        $display("Checks: %0d mismatches: %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        t_refresh;
        t_burst4;
        t_mrs;
        t_wrec;
        wrap_up;
    end

    // Run needs a few hundred cycles at most
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        wrap_up;
    end
endmodule

`default_nettype wire
